// *** verilog/pll_ctl_cfg.svh ***
// Constants for the synthesizer power and lock detect controller.
// Assumes inclusion by bare name from any design file; definitions only.
`ifndef PLL_CTL_CFG_SVH
`define PLL_CTL_CFG_SVH

// Register byte offsets on the Wishbone slave.
`define OFS_CONTROL        8'h00
`define OFS_RF_NCOUNT      8'h04
`define OFS_STATUS         8'h08
`define OFS_ACQ_TIMEOUT    8'h0c

// Control register field positions.
`define CTL_RF_SECTION_POWER_DOWN_BIT      0
`define CTL_IF_SECTION_POWER_DOWN_BIT      1
`define CTL_AUTO_POWER_UP_ON_WRITE_BIT       2
`define CTL_QRATE_BIT      3
`define CTL_SEL_LSB        4
`define CTL_SEL_MSB        7
`define CTL_CSR_LSB        8
`define CTL_CSR_MSB        9
`define CTL_FASTLOCK_BIT   10
`define CTL_WIDTH          11

// Reset values: both sections powered down, selector driving low.
`define CTL_RESET          11'h003
`define TIMEOUT_RESET      16'h0100

// Test/lock selector codes.
`define SEL_LOW            4'h0
`define SEL_HIGH           4'h1
`define SEL_RF_LOCK        4'h2
`define SEL_IF_LOCK        4'h3
`define SEL_BOTH_LOCK      4'h4

// Lock detector windows in ns and the in-window cycle count.
`define RF_ENTRY_NS        10
`define RF_EXIT_NS         20
`define IF_ENTRY_NS        15
`define IF_EXIT_NS         30
`define LOCK_CYCLES        5
`define LD_DIVIDE          4

`endif

// *** verilog/pll_ctl_pkg.sv ***
// Types shared by the synthesizer power and lock detect controller.
// Assumes nothing beyond a SystemVerilog compiler.
package pll_ctl_pkg;

	// Cycle slip reduction factor as held in the control register.
	typedef enum logic [1:0] {
		CSR_OFF,
		CSR_HALF,
		CSR_QUARTER,
		CSR_SIXTEENTH
	} csr_factor_type;

	// Acquisition aid sequencer states.
	typedef enum logic [1:0] {
		ACQ_IDLE,
		ACQ_SLIP,
		ACQ_FAST
	} acq_state_type;

endpackage

// *** verilog/lock_ctl_if.sv ***
// Carrier between the controller top and one lock window detector.
// Assumes one instance per PLL, all on mclk.
`timescale 1ns/1ps
interface lock_ctl_if;
	logic       ref_tick;
	logic [7:0] phase_err;
	logic       enable;
	logic       init;
	logic       quarter_rate;
	logic       locked;

	modport det (input ref_tick, phase_err, enable, init, quarter_rate, output locked);
	modport ctl (output ref_tick, phase_err, enable, init, quarter_rate, input locked);
endinterface

// *** verilog/lock_window_detector.sv ***
// Hysteretic digital lock detector for one PLL.
// Assumes ref_tick pulses once per comparison cycle with phase_err in ns valid.
`timescale 1ns/1ps
`include "pll_ctl_cfg.svh"
module lock_window_detector import pll_ctl_pkg::*; #(
	parameter int ENTRY_NS = `RF_ENTRY_NS,
	parameter int EXIT_NS  = `RF_EXIT_NS
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst,
	// Detector side of the carrier.
	lock_ctl_if.det  lk
);
	localparam logic [7:0] ENTRY_W = 8'(ENTRY_NS);
	localparam logic [7:0] EXIT_W  = 8'(EXIT_NS);
	localparam logic [2:0] LAST    = 3'(`LOCK_CYCLES - 1);
	localparam logic [1:0] PRE_TOP = 2'(`LD_DIVIDE - 1);

	logic [1:0] pre_q;
	logic [2:0] cnt_q;
	logic       locked_q;
	logic       vtick;

	// Only every fourth comparison reaches the detector when quarter rate is on.
	assign vtick = lk.ref_tick && (!lk.quarter_rate || pre_q == PRE_TOP);

	// Comparison prescaler.
	always_ff @(posedge mclk) begin
		if (rst || lk.init || !lk.enable)
			pre_q <= 2'h0;
		else if (lk.ref_tick)
			pre_q <= pre_q + 2'h1;
	end

	// In-window counting and lock state; a counter write restarts the detector.
	always_ff @(posedge mclk) begin
		if (rst || lk.init || !lk.enable) begin
			cnt_q    <= 3'h0;
			locked_q <= 1'b0;
		end else if (vtick) begin
			if (locked_q) begin
				if (lk.phase_err > EXIT_W) begin
					locked_q <= 1'b0;
					cnt_q    <= 3'h0;
				end
			end else if (lk.phase_err < ENTRY_W) begin
				if (cnt_q == LAST)
					locked_q <= 1'b1;
				else
					cnt_q <= cnt_q + 3'h1;
			end else begin
				cnt_q <= 3'h0;
			end
		end
	end

	assign lk.locked = locked_q;

	AST_LOCK_AFTER_FIVE: assert property (@(posedge mclk) disable iff (rst)
		$rose(locked_q) |-> $past(cnt_q) == 3'h4 && $past(lk.phase_err) < ENTRY_W)
		else $error("Lock rose without five in-window cycles.");
	AST_EXIT_DROPS: assert property (@(posedge mclk) disable iff (rst)
		locked_q && vtick && lk.phase_err > EXIT_W |=> !locked_q)
		else $error("Lock held past the exit window.");
	AST_WIDE_HOLD: assert property (@(posedge mclk) disable iff (rst)
		locked_q && lk.enable && !lk.init && !(vtick && lk.phase_err > EXIT_W) |=> locked_q)
		else $error("Lock dropped inside the exit window.");
	AST_COUNT_RESTART: assert property (@(posedge mclk) disable iff (rst)
		!locked_q && lk.enable && !lk.init && vtick && lk.phase_err >= ENTRY_W |=> cnt_q == 3'h0)
		else $error("In-window count not restarted.");
endmodule // lock_window_detector

// *** verilog/acq_aid_sequencer.sv ***
// Engages cycle slip reduction or fast-lock for a timed acquisition after a counter write.
// Assumes start is a one-cycle pulse and timeout counts mclk cycles.
`timescale 1ns/1ps
module acq_aid_sequencer import pll_ctl_pkg::*; (
	// Clock and reset.
	input  wire logic           mclk,
	input  wire logic           rst,
	// Control.
	input  wire logic           start,
	input  wire logic           powered,
	input  wire csr_factor_type csr_factor,
	input  wire logic           fast_en,
	input  wire logic [15:0]    timeout,
	// Loop controls.
	output logic [2:0]          rate_shift,
	output logic                cp_boost,
	output logic                res_switch,
	output logic                slip_active,
	output logic                fast_active
);
	acq_state_type state_q;
	logic [15:0]   tmr_q;
	logic [15:0]   slip_end;

	// Slip reduction lets go at a quarter of the timeout, near the transient peak.
	assign slip_end = timeout >> 2;

	// Sequencer; slip reduction takes precedence if software enables both.
	always_ff @(posedge mclk) begin
		if (rst || !powered) begin
			state_q <= ACQ_IDLE;
			tmr_q   <= 16'h0000;
		end else if (start) begin
			tmr_q <= 16'h0000;
			if (csr_factor != CSR_OFF)
				state_q <= ACQ_SLIP;
			else if (fast_en)
				state_q <= ACQ_FAST;
			else
				state_q <= ACQ_IDLE;
		end else begin
			unique case (state_q)
				ACQ_IDLE: tmr_q <= 16'h0000;
				ACQ_SLIP: begin
					tmr_q <= tmr_q + 16'h0001;
					if (tmr_q >= slip_end)
						state_q <= ACQ_IDLE;
				end
				ACQ_FAST: begin
					tmr_q <= tmr_q + 16'h0001;
					if (tmr_q >= timeout)
						state_q <= ACQ_IDLE;
				end
				default: state_q <= ACQ_IDLE;
			endcase
		end
	end

	// Comparison divide as log2 and fast-lock gain drives, all registered.
	always_ff @(posedge mclk) begin
		if (rst) begin
			rate_shift <= 3'h0;
			cp_boost   <= 1'b0;
			res_switch <= 1'b0;
		end else begin
			rate_shift <= 3'h0;
			if (state_q == ACQ_SLIP) begin
				unique case (csr_factor)
					CSR_HALF:      rate_shift <= 3'h1;
					CSR_QUARTER:   rate_shift <= 3'h2;
					CSR_SIXTEENTH: rate_shift <= 3'h4;
					CSR_OFF:       rate_shift <= 3'h0;
				endcase
			end
			cp_boost   <= state_q == ACQ_FAST;
			res_switch <= state_q == ACQ_FAST;
		end
	end

	assign slip_active = state_q == ACQ_SLIP;
	assign fast_active = state_q == ACQ_FAST;

	AST_SLIP_ALONE: assert property (@(posedge mclk) disable iff (rst)
		slip_active |=> !cp_boost && !res_switch)
		else $error("Slip reduction changed the loop bandwidth.");
	AST_SLIP_ENDS: assert property (@(posedge mclk) disable iff (rst)
		slip_active && !start && tmr_q >= slip_end |=> !slip_active)
		else $error("Slip reduction did not disengage.");
endmodule // acq_aid_sequencer

// *** verilog/pll_power_lock_detect.sv ***
// Power state, lock detection and acquisition aid control for a dual synthesizer.
// Assumes a classic Wishbone master on mclk and per-PLL phase error samples in ns.
//
// Overview of operation
// - Chip enable low powers everything down, overriding all bits.
// - Auto power-up plus an RF counter write powers the RF section.
// - Both section power-down bits clear with chip enable high: all powered.
// - A set section bit powers that section down, unless auto power-up wins.
// - Lock rises after five successive cycles under the entry window.
// - Once locked the window widens; lock falls when error exceeds it.
// - A powered-down PLL forces the lock pin low when lock is shown.
// - Quarter rate option divides comparisons into the detector by four.
// - Combined lock view is the AND of both lock states.
// - Slip reduction scales the comparison rate by 1/2, 1/4 or 1/16.
// - Slip reduction lowers comparison rate in acquisition, then lets go.
// - Fast-lock boosts pump current and switches the resistor in acquisition only.
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "pll_ctl_cfg.svh"
module pll_power_lock_detect import pll_ctl_pkg::*; (
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        rst,
	// Wishbone slave.
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Chip enable pin.
	input  wire logic        chip_enable,
	// Phase detector samples.
	input  wire logic        rf_ref_tick,
	input  wire logic [7:0]  rf_phase_err,
	input  wire logic        if_ref_tick,
	input  wire logic [7:0]  if_phase_err,
	// Power and loop controls.
	output logic             rf_power_up,
	output logic             if_power_up,
	output logic [2:0]       csr_rate_shift,
	output logic             cp_current_boost,
	output logic             loop_resistor_switch,
	// Test and lock pin.
	output logic             test_lock_output_pin
);
	logic [`CTL_WIDTH-1:0] ctrl_q;
	logic [15:0]           timeout_q;
	logic [15:0]           ncount_q;
	logic                  ack_q;
	logic [31:0]           rdata_q;
	logic                  auto_power_up_on_write_hold_q;
	logic                  pin_q;
	logic                  req;
	logic                  wr_now;
	logic                  n_write;
	logic                  rf_section_power_down;
	logic                  if_section_power_down;
	logic                  auto_power_up_on_write;
	logic [3:0]            sel;
	logic                  rf_locked;
	logic                  if_locked;
	logic                  slip_active;
	logic                  fast_active;
	logic [1:0]            powered;
	logic [1:0]            ticks;
	logic [7:0]            errs [2];

	// Bus request qualifiers; a write commits only at the edge where ack is seen.
	assign req     = wb_cyc_i && wb_stb_i;
	assign wr_now  = req && wb_we_i && ack_q;
	assign n_write = wr_now && wb_adr_i == `OFS_RF_NCOUNT;

	// Control field views.
	assign rf_section_power_down = ctrl_q[`CTL_RF_SECTION_POWER_DOWN_BIT];
	assign if_section_power_down = ctrl_q[`CTL_IF_SECTION_POWER_DOWN_BIT];
	assign auto_power_up_on_write  = ctrl_q[`CTL_AUTO_POWER_UP_ON_WRITE_BIT];
	assign sel   = ctrl_q[`CTL_SEL_MSB:`CTL_SEL_LSB];

	// Ack one cycle after the request and drop it the next, so every access takes two edges.
	always_ff @(posedge mclk) begin
		if (rst)
			ack_q <= 1'b0;
		else
			ack_q <= req && !ack_q;
	end

	assign wb_ack_o = ack_q;

	// Control register with byte lanes; unmapped writes are acknowledged and dropped.
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_q <= `CTL_RESET;
		end else if (wr_now && wb_adr_i == `OFS_CONTROL) begin
			if (wb_sel_i[0])
				ctrl_q[7:0] <= wb_dat_i[7:0];
			if (wb_sel_i[1])
				ctrl_q[`CTL_WIDTH-1:8] <= wb_dat_i[`CTL_WIDTH-1:8];
		end
	end

	// Acquisition timeout register.
	always_ff @(posedge mclk) begin
		if (rst) begin
			timeout_q <= `TIMEOUT_RESET;
		end else if (wr_now && wb_adr_i == `OFS_ACQ_TIMEOUT) begin
			if (wb_sel_i[0])
				timeout_q[7:0] <= wb_dat_i[7:0];
			if (wb_sel_i[1])
				timeout_q[15:8] <= wb_dat_i[15:8];
		end
	end

	// RF counter holding word; the write itself is the event that matters here.
	always_ff @(posedge mclk) begin
		if (rst) begin
			ncount_q <= 16'h0000;
		end else if (n_write) begin
			if (wb_sel_i[0])
				ncount_q[7:0] <= wb_dat_i[7:0];
			if (wb_sel_i[1])
				ncount_q[15:8] <= wb_dat_i[15:8];
		end
	end

	// Read data is captured in the request cycle and presented with ack.
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (req && !ack_q) begin
			unique case (wb_adr_i)
				`OFS_CONTROL:     rdata_q <= {21'h000000, ctrl_q};
				`OFS_RF_NCOUNT:   rdata_q <= {16'h0000, ncount_q};
				`OFS_STATUS:      rdata_q <= {26'h0000000, fast_active, slip_active,
					if_locked, rf_locked, if_power_up, rf_power_up};
				`OFS_ACQ_TIMEOUT: rdata_q <= {16'h0000, timeout_q};
				default:          rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign wb_dat_o = rdata_q;

	// Auto power-up memory: a counter write with the option on keeps the RF section up
	// until chip enable falls or software withdraws the option.
	always_ff @(posedge mclk) begin
		if (rst || !chip_enable || !auto_power_up_on_write)
			auto_power_up_on_write_hold_q <= 1'b0;
		else if (n_write)
			auto_power_up_on_write_hold_q <= 1'b1;
	end

	// Power resolution is combinational so chip enable and the bits act without a clock edge.
	// The same-edge counter write is folded in so auto power-up is never a cycle late.
	assign rf_power_up = chip_enable && (!rf_section_power_down || auto_power_up_on_write_hold_q || (auto_power_up_on_write && n_write));
	assign if_power_up = chip_enable && !if_section_power_down;

	// Per-PLL inputs to the detectors.
	assign powered = {if_power_up, rf_power_up};
	assign ticks   = {if_ref_tick, rf_ref_tick};
	assign errs[0] = rf_phase_err;
	assign errs[1] = if_phase_err;

	// One lock detector per PLL; index 0 is RF, 1 is IF.
	for (genvar p = 0; p < 2; p++) begin : g_pll
		lock_ctl_if lk ();
		assign lk.ref_tick     = ticks[p];
		assign lk.phase_err    = errs[p];
		assign lk.enable       = powered[p];
		assign lk.init         = n_write;
		assign lk.quarter_rate = ctrl_q[`CTL_QRATE_BIT];
		lock_window_detector #(
			.ENTRY_NS (p == 0 ? `RF_ENTRY_NS : `IF_ENTRY_NS),
			.EXIT_NS  (p == 0 ? `RF_EXIT_NS : `IF_EXIT_NS)
		) u_det (
			.mclk (mclk),
			.rst  (rst),
			.lk   (lk)
		);
	end

	assign rf_locked = g_pll[0].lk.locked;
	assign if_locked = g_pll[1].lk.locked;

	// Acquisition aids for the RF loop, started by the counter write.
	acq_aid_sequencer u_acq (
		.mclk        (mclk),
		.rst         (rst),
		.start       (n_write),
		.powered     (rf_power_up),
		.csr_factor  (csr_factor_type'(ctrl_q[`CTL_CSR_MSB:`CTL_CSR_LSB])),
		.fast_en     (ctrl_q[`CTL_FASTLOCK_BIT]),
		.timeout     (timeout_q),
		.rate_shift  (csr_rate_shift),
		.cp_boost    (cp_current_boost),
		.res_switch  (loop_resistor_switch),
		.slip_active (slip_active),
		.fast_active (fast_active)
	);

	// Test/lock pin; a powered-down PLL is gated here too, not only through its detector.
	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_q <= 1'b0;
		end else begin
			unique case (sel)
				`SEL_HIGH:      pin_q <= 1'b1;
				`SEL_RF_LOCK:   pin_q <= rf_locked && rf_power_up;
				`SEL_IF_LOCK:   pin_q <= if_locked && if_power_up;
				`SEL_BOTH_LOCK: pin_q <= rf_locked && if_locked && rf_power_up && if_power_up;
				default:        pin_q <= 1'b0;
			endcase
		end
	end

	assign test_lock_output_pin = pin_q;

	// Sequences used by the checks below.
	sequence n_write_s;
		chip_enable && auto_power_up_on_write && n_write;
	endsequence

	sequence both_sel_s;
		sel == `SEL_BOTH_LOCK && !(rf_locked && if_locked);
	endsequence

	AST_CE_OFF: assert property (@(posedge mclk) disable iff (rst)
		!chip_enable |-> !rf_power_up && !if_power_up)
		else $error("Section powered with chip enable low.");
	AST_AUTO_POWER_UP_ON_WRITE_UP: assert property (@(posedge mclk) disable iff (rst)
		n_write_s |-> rf_power_up ##1 (rf_power_up || !chip_enable || !auto_power_up_on_write))
		else $error("Auto power-up did not power the RF section.");
	AST_ALL_UP: assert property (@(posedge mclk) disable iff (rst)
		chip_enable && !rf_section_power_down && !if_section_power_down |-> rf_power_up && if_power_up)
		else $error("Device not fully powered with both bits clear.");
	AST_RF_DOWN: assert property (@(posedge mclk) disable iff (rst)
		rf_section_power_down && !auto_power_up_on_write_hold_q && !n_write |-> !rf_power_up)
		else $error("RF section up despite its power-down bit.");
	AST_IF_DOWN: assert property (@(posedge mclk) disable iff (rst)
		if_section_power_down |-> !if_power_up ##1 !if_locked)
		else $error("IF section up despite its power-down bit.");
	AST_PIN_FORCED_LOW: assert property (@(posedge mclk) disable iff (rst)
		sel == `SEL_RF_LOCK && !rf_power_up |=> !test_lock_output_pin)
		else $error("Lock pin not forced low while RF is down.");
	AST_BOTH_AND: assert property (@(posedge mclk) disable iff (rst)
		both_sel_s |=> !test_lock_output_pin)
		else $error("Combined lock view high with one PLL unlocked.");
	AST_ACK_PULSE: assert property (@(posedge mclk) disable iff (rst)
		wb_ack_o |=> !wb_ack_o)
		else $error("Ack held for more than one cycle.");

	// Pin views: a powered-down PLL never shows lock, a locked and powered one always does.
	AST_PIN_IF_LOW: assert property (@(posedge mclk) disable iff (rst)
		sel == `SEL_IF_LOCK && !if_power_up |=> !test_lock_output_pin)
		else $error("Lock pin not forced low while IF is down.");
	AST_PIN_BOTH_LOW: assert property (@(posedge mclk) disable iff (rst)
		sel == `SEL_BOTH_LOCK && !(rf_power_up && if_power_up) |=> !test_lock_output_pin)
		else $error("Combined lock view high with a section down.");
	AST_PIN_RF_SHOWS: assert property (@(posedge mclk) disable iff (rst)
		sel == `SEL_RF_LOCK && rf_locked && rf_power_up |=> test_lock_output_pin)
		else $error("Lock pin low although RF is locked.");
	AST_BOTH_HIGH: assert property (@(posedge mclk) disable iff (rst)
		sel == `SEL_BOTH_LOCK && rf_locked && if_locked && rf_power_up && if_power_up |=> test_lock_output_pin)
		else $error("Combined lock view low with both PLLs locked.");

	// Detector restarts: power-down and a counter write both drop lock at the next edge.
	AST_RF_DOWN_UNLOCKS: assert property (@(posedge mclk) disable iff (rst)
		!rf_power_up |=> !rf_locked)
		else $error("RF lock kept while the section is down.");
	AST_N_WRITE_RESTARTS: assert property (@(posedge mclk) disable iff (rst)
		n_write |=> !rf_locked && !if_locked)
		else $error("Counter write did not restart lock detection.");

	// Acquisition aids: what starts them and what they drive while engaged.
	AST_SLIP_START: assert property (@(posedge mclk) disable iff (rst)
		n_write && rf_power_up && ctrl_q[`CTL_CSR_MSB:`CTL_CSR_LSB] != 2'h0 |=> slip_active)
		else $error("Counter write did not engage slip reduction.");
	AST_FAST_START: assert property (@(posedge mclk) disable iff (rst)
		n_write && rf_power_up && ctrl_q[`CTL_CSR_MSB:`CTL_CSR_LSB] == 2'h0
		&& ctrl_q[`CTL_FASTLOCK_BIT] |=> fast_active)
		else $error("Counter write did not engage fast-lock.");
	AST_FAST_GAIN: assert property (@(posedge mclk) disable iff (rst)
		fast_active |=> cp_current_boost && loop_resistor_switch)
		else $error("Fast-lock engaged without boost and resistor.");
	AST_GAIN_ONLY_FAST: assert property (@(posedge mclk) disable iff (rst)
		!fast_active |=> !cp_current_boost && !loop_resistor_switch)
		else $error("Boost or resistor applied outside fast-lock.");
	AST_RATE_ONLY_SLIP: assert property (@(posedge mclk) disable iff (rst)
		!slip_active |=> csr_rate_shift == 3'h0)
		else $error("Comparison rate lowered outside slip reduction.");
	AST_RATE_SIXTEENTH: assert property (@(posedge mclk) disable iff (rst)
		slip_active && ctrl_q[`CTL_CSR_MSB:`CTL_CSR_LSB] == 2'h3 |=> csr_rate_shift == 3'h4)
		else $error("Sixteenth factor not applied.");

	// Bus answer timing: one ack per request, none while idle.
	AST_ACK_ANSWERS: assert property (@(posedge mclk) disable iff (rst)
		req && !wb_ack_o |=> wb_ack_o)
		else $error("Request not answered in the next cycle.");
	AST_ACK_IDLE: assert property (@(posedge mclk) disable iff (rst)
		!req |=> !wb_ack_o)
		else $error("Ack given without a request.");
endmodule // pll_power_lock_detect

// *** verification/phase_sample_source.sv ***
// Stand-in for one PLL's phase detector: emits a tick and a phase error sample each period.
// Assumes the bench sets err_set on rising edges of mclk; ticks run freely after reset.
`timescale 1ns/1ps
module phase_sample_source #(
	parameter int PERIOD = 4
) (
	// Clock and reset.
	input  wire logic       mclk,
	input  wire logic       rst,
	// Error to present at the next tick.
	input  wire logic [7:0] err_set,
	// Samples towards the block.
	output logic            tick,
	output logic [7:0]      err
);
	logic [7:0] cnt_q;

	// One tick per period; between ticks the error bus flips so a stale value is never usable.
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q <= 8'h00;
			tick  <= 1'b0;
			err   <= 8'hff;
		end else begin
			cnt_q <= (cnt_q == 8'(PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
			tick  <= (cnt_q == 8'(PERIOD - 1));
			err   <= (cnt_q == 8'(PERIOD - 1)) ? err_set : ~err;
		end
	end
endmodule // phase_sample_source

// *** verification/pll_power_lock_detect_tb.sv ***
// Self-checking bench for the power, lock detect and acquisition aid controller.
// Assumes the design files compile first; registers are reached over classic Wishbone.
`timescale 1ns/1ps
`include "pll_ctl_cfg.svh"
module pll_power_lock_detect_tb import pll_ctl_pkg::*;;
	logic        mclk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, chip_enable;
	logic [7:0]  wb_adr_i, rf_err_set, if_err_set, rf_phase_err, if_phase_err;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd_q;
	logic        rf_ref_tick, if_ref_tick, rf_power_up, if_power_up;
	logic        cp_current_boost, loop_resistor_switch, test_lock_output_pin;
	logic [2:0]  csr_rate_shift;
	int          n_fail, total_checks;

	pll_power_lock_detect i_pll_power_lock_detect (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chip_enable(chip_enable),
		.rf_ref_tick(rf_ref_tick), .rf_phase_err(rf_phase_err), .if_ref_tick(if_ref_tick),
		.if_phase_err(if_phase_err), .rf_power_up(rf_power_up), .if_power_up(if_power_up),
		.csr_rate_shift(csr_rate_shift), .cp_current_boost(cp_current_boost),
		.loop_resistor_switch(loop_resistor_switch), .test_lock_output_pin(test_lock_output_pin));
	phase_sample_source i_phase_sample_source_rf (.mclk(mclk), .rst(rst), .err_set(rf_err_set),
		.tick(rf_ref_tick), .err(rf_phase_err));
	phase_sample_source i_phase_sample_source_if (.mclk(mclk), .rst(rst), .err_set(if_err_set),
		.tick(if_ref_tick), .err(if_phase_err));

	// Free-running 100 MHz clock.
	always #5 mclk = ~mclk;

	// Compares and counts; a mismatch is reported at once.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One classic cycle; the request holds until ack is sampled, then the bus idles a cycle.
	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= 4'hf;
		do begin
			@(posedge mclk);
		end while (wb_ack_o !== 1'b1);
		rd_q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		wb_cycle(1'b1, adr, dat);
	endtask

	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
		wb_cycle(1'b0, adr, 32'h0);
		check(rd_q, exp);
	endtask

	// Power outputs are combinational, so they are looked at 1 ns after an edge.
	task automatic pwr_chk(input logic [1:0] exp);
		@(posedge mclk);
		#1;
		check({30'h0, rf_power_up, if_power_up}, {30'h0, exp});
		@(posedge mclk);
	endtask

	// Waits for n comparison ticks of the sample sources.
	task automatic ticks(input int n);
		repeat (n * 4) @(posedge mclk);
	endtask

	task automatic finish_test;
		if (n_fail == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Cuts a hang short well beyond the few hundred cycles the tests need.
	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		finish_test;
	end

	// Main sequence.
	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		chip_enable = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		rf_err_set = 8'hff;
		if_err_set = 8'hff;
		n_fail = 0;
		total_checks = 0;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rd_chk(`OFS_CONTROL, 32'h0000_0003);
		rd_chk(`OFS_ACQ_TIMEOUT, 32'h0000_0100);
		wr(8'h10, 32'h0000_00ff);
		rd_chk(8'h10, 32'h0000_0000);
		// Power resolution: section bits, auto power-up, then chip enable over all.
		wr(`OFS_CONTROL, 32'h0000_0000);
		pwr_chk(2'b11);
		wr(`OFS_CONTROL, 32'h0000_0001);
		pwr_chk(2'b01);
		wr(`OFS_CONTROL, 32'h0000_0002);
		pwr_chk(2'b10);
		wr(`OFS_CONTROL, 32'h0000_0005);
		pwr_chk(2'b01);
		wr(`OFS_RF_NCOUNT, 32'h0000_0123);
		pwr_chk(2'b11);
		chip_enable <= 1'b0;
		pwr_chk(2'b00);
		rd_chk(`OFS_STATUS, 32'h0000_0000);
		chip_enable <= 1'b1;
		pwr_chk(2'b01);
		// RF lock: a boundary error of exactly the entry window restarts the count.
		wr(`OFS_CONTROL, 32'h0000_0020);
		wr(`OFS_RF_NCOUNT, 32'h0000_0123);
		rf_err_set <= 8'd5;
		ticks(4);
		rf_err_set <= 8'd10;
		ticks(1);
		rf_err_set <= 8'd5;
		ticks(4);
		rf_err_set <= 8'd10;
		rd_chk(`OFS_STATUS, 32'h0000_0003);
		rf_err_set <= 8'd5;
		ticks(5);
		rd_chk(`OFS_STATUS, 32'h0000_0007);
		check(test_lock_output_pin, 1'b1);
		rf_err_set <= 8'd20;
		ticks(3);
		rd_chk(`OFS_STATUS, 32'h0000_0007);
		rf_err_set <= 8'd21;
		ticks(2);
		rd_chk(`OFS_STATUS, 32'h0000_0003);
		check(test_lock_output_pin, 1'b0);
		// Combined view of both detectors.
		rf_err_set <= 8'd5;
		ticks(5);
		wr(`OFS_CONTROL, 32'h0000_0040);
		ticks(1);
		check(test_lock_output_pin, 1'b0);
		if_err_set <= 8'd14;
		ticks(5);
		rd_chk(`OFS_STATUS, 32'h0000_000f);
		check(test_lock_output_pin, 1'b1);
		if_err_set <= 8'd30;
		ticks(2);
		check(test_lock_output_pin, 1'b1);
		rf_err_set <= 8'd21;
		ticks(2);
		check(test_lock_output_pin, 1'b0);
		// A powered-down RF section forces the lock pin low.
		if_err_set <= 8'hff;
		rf_err_set <= 8'd5;
		ticks(5);
		wr(`OFS_CONTROL, 32'h0000_0021);
		ticks(1);
		check(test_lock_output_pin, 1'b0);
		// Quarter rate: eight raw ticks are too few, twenty-four are plenty.
		wr(`OFS_CONTROL, 32'h0000_0028);
		wr(`OFS_RF_NCOUNT, 32'h0000_0123);
		ticks(8);
		rd_chk(`OFS_STATUS, 32'h0000_0003);
		ticks(16);
		rd_chk(`OFS_STATUS, 32'h0000_0007);
		// Acquisition aids, never both at once and with a short timeout.
		wr(`OFS_ACQ_TIMEOUT, 32'h0000_0020);
		for (int f = 1; f < 4; f++) begin
			wr(`OFS_CONTROL, 32'(f) << 8);
			wr(`OFS_RF_NCOUNT, 32'h0000_0123);
			repeat (4) @(posedge mclk);
			check(csr_rate_shift, (f == 3) ? 32'h4 : 32'(f));
			check({cp_current_boost, loop_resistor_switch}, 32'h0);
			rd_chk(`OFS_STATUS, 32'h0000_0013);
			repeat (40) @(posedge mclk);
			check(csr_rate_shift, 32'h0);
		end
		wr(`OFS_CONTROL, 32'h0000_0400);
		wr(`OFS_RF_NCOUNT, 32'h0000_0123);
		repeat (4) @(posedge mclk);
		check({cp_current_boost, loop_resistor_switch}, 32'h3);
		check(csr_rate_shift, 32'h0);
		rd_chk(`OFS_STATUS, 32'h0000_0023);
		repeat (40) @(posedge mclk);
		check({cp_current_boost, loop_resistor_switch}, 32'h0);
		// IF lock on the pin, forced low when IF powers down, then the fixed high level.
		if_err_set <= 8'd14;
		wr(`OFS_CONTROL, 32'h0000_0030);
		ticks(6);
		check(test_lock_output_pin, 1'b1);
		wr(`OFS_CONTROL, 32'h0000_0032);
		ticks(1);
		check(test_lock_output_pin, 1'b0);
		wr(`OFS_CONTROL, 32'h0000_0012);
		ticks(1);
		check(test_lock_output_pin, 1'b1);
		finish_test;
	end
endmodule // pll_power_lock_detect_tb
